// ==== rtl/evh_top.sv ====
// event handler: eight latched event flags, two cpu event levels, wishbone registers
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "evh_map.svh"
module evh_top
  import evh_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output var  logic [31:0] WB_DAT_O,
  output var  logic        WB_ACK_O,
  output var  logic        WB_ERR_O,
  input  wire logic [7:0]  EVENT_SRC,
  output var  logic        CPU_EVENT_LINE_ZERO,
  output var  logic        CPU_EVENT_LINE_ONE
);
  evh_src_if src_if ();

  evh_byte_t  event_flags_q;
  evh_byte_t  event_flags_d;
  evh_byte_t  event_enables_q;
  evh_byte_t  top_event_code_q;
  evh_byte_t  top_event_code_d;
  logic [1:0] event_level_summary_q;
  logic       high_group_pending;
  logic       low_group_pending;
  logic       req;
  logic       wr_lane0;
  logic       rd_lane0;
  evh_sel_t   sel;
  evh_byte_t  clear_mask;
  evh_byte_t  rd_byte;

  // pin sources pass the synchroniser before any edge test
  evh_edge #(
    .N (`EVH_NUM_EVENTS)
  ) u_edge (
    .clk     (CORE_CLK),
    .rst_n   (NRST),
    .src_raw (EVENT_SRC),
    .out_if  (src_if)
  );

  // a new request is one not yet answered; ack drops the cycle after
  assign req      = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
  assign wr_lane0 = req & WB_WE_I & WB_SEL_I[0] & (sel != EVH_SEL_NONE);
  assign rd_lane0 = WB_SEL_I[0];

  // address decode
  always_comb begin
    if (WB_ADR_I == `EVH_OFS_FLAGS) begin
      sel = EVH_SEL_FLAGS;
    end else if (WB_ADR_I == `EVH_OFS_ENABLES) begin
      sel = EVH_SEL_ENABLES;
    end else if (WB_ADR_I == `EVH_OFS_TOP_CODE) begin
      sel = EVH_SEL_TOP_CODE;
    end else if (WB_ADR_I == `EVH_OFS_SUMMARY) begin
      sel = EVH_SEL_SUMMARY;
    end else begin
      sel = EVH_SEL_NONE;
    end
  end

  // write-one-to-clear mask, only from lane 0 of an accepted write
  always_comb begin
    clear_mask = '0;
    if (wr_lane0 && sel == EVH_SEL_FLAGS) begin
      clear_mask = WB_DAT_I[7:0];
    end
  end

  // set beats clear so an edge in the clearing cycle is never lost
  always_comb begin
    event_flags_d = (event_flags_q & ~clear_mask)
                  | (src_if.rise & event_enables_q);
  end

  // flags hold until cleared by software or reset
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      event_flags_q <= `EVH_RST_FLAGS;
    end else begin
      event_flags_q <= event_flags_d;
    end
  end

  // enable register, plain read/write
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      event_enables_q <= `EVH_RST_ENABLES;
    end else if (wr_lane0 && sel == EVH_SEL_ENABLES) begin
      event_enables_q <= WB_DAT_I[7:0];
    end
  end

  // fixed priority: the highest index set wins, scanning upward
  always_comb begin
    top_event_code_d = `EVH_NO_EVENT_CODE;
    for (int i = 0; i < `EVH_NUM_EVENTS; i++) begin
      if (event_flags_q[i]) begin
        top_event_code_d = 8'(i);
      end
    end
  end

  assign high_group_pending = |event_flags_q[`EVH_HIGH_MSB:`EVH_HIGH_LSB];
  assign low_group_pending  = |event_flags_q[`EVH_LOW_MSB:`EVH_LOW_LSB];

  // derived status is registered, so it trails the flags by one cycle
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      top_event_code_q      <= `EVH_RST_TOP_CODE;
      event_level_summary_q <= `EVH_RST_SUMMARY;
    end else begin
      top_event_code_q                        <= top_event_code_d;
      event_level_summary_q[`EVH_SUM_HIGH_BIT] <= high_group_pending;
      event_level_summary_q[`EVH_SUM_LOW_BIT]  <= low_group_pending;
    end
  end

  // held cpu event levels: high group on line zero, low group on line one
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      CPU_EVENT_LINE_ZERO <= 1'b0;
      CPU_EVENT_LINE_ONE  <= 1'b0;
    end else begin
      CPU_EVENT_LINE_ZERO <= high_group_pending;
      CPU_EVENT_LINE_ONE  <= low_group_pending;
    end
  end

  // read mux; bits above the byte and unused summary bits read zero
  always_comb begin
    rd_byte = '0;
    case (sel)
      EVH_SEL_FLAGS: begin
        rd_byte = event_flags_q;
      end
      EVH_SEL_ENABLES: begin
        rd_byte = event_enables_q;
      end
      EVH_SEL_TOP_CODE: begin
        rd_byte = top_event_code_q;
      end
      EVH_SEL_SUMMARY: begin
        rd_byte = {6'h00, event_level_summary_q};
      end
      default: begin
        rd_byte = '0;
      end
    endcase
    if (!rd_lane0) begin
      rd_byte = '0;
    end
  end

  // one-cycle answer: ack for mapped offsets, err for the rest
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req & (sel != EVH_SEL_NONE);
      WB_ERR_O <= req & (sel == EVH_SEL_NONE);
      if (req && !WB_WE_I) begin
        WB_DAT_O <= {24'h000000, rd_byte};
      end else begin
        WB_DAT_O <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/evh_map.svh ====
// register offsets, field positions and reset values of the event handler
`ifndef EVH_MAP_SVH
`define EVH_MAP_SVH

`define EVH_NUM_EVENTS     8
`define EVH_GROUP_SIZE     4
`define EVH_HIGH_MSB       7
`define EVH_HIGH_LSB       4
`define EVH_LOW_MSB        3
`define EVH_LOW_LSB        0

`define EVH_ADR_W          8
`define EVH_OFS_FLAGS      8'h00
`define EVH_OFS_ENABLES    8'h04
`define EVH_OFS_TOP_CODE   8'h08
`define EVH_OFS_SUMMARY    8'h0C

`define EVH_RST_FLAGS      8'h00
`define EVH_RST_ENABLES    8'h00
`define EVH_RST_TOP_CODE   8'hFF
`define EVH_RST_SUMMARY    2'h0
`define EVH_NO_EVENT_CODE  8'hFF

`define EVH_SUM_HIGH_BIT   1
`define EVH_SUM_LOW_BIT    0

`endif

// ==== rtl/evh_pkg.sv ====
// types shared by the event handler modules
package evh_pkg;
  typedef logic [7:0] evh_byte_t;
  typedef logic [2:0] evh_index_t;
  typedef enum {
    EVH_SEL_FLAGS,
    EVH_SEL_ENABLES,
    EVH_SEL_TOP_CODE,
    EVH_SEL_SUMMARY,
    EVH_SEL_NONE
  } evh_sel_t;
endpackage

// ==== rtl/evh_src_if.sv ====
// carrier of filtered source levels and rising-edge pulses
`timescale 1ns/1ps
`default_nettype none
interface evh_src_if;
  logic [7:0] level;
  logic [7:0] rise;
  modport producer (output level, output rise);
  modport consumer (input level, input rise);
endinterface
`default_nettype wire

// ==== rtl/evh_edge.sv ====
// three-stage synchroniser, agreement filter and rising-edge detector per source
`timescale 1ns/1ps
`default_nettype none
`include "evh_map.svh"
module evh_edge
  import evh_pkg::*;
#(
  parameter int N = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] src_raw,
  evh_src_if.producer       out_if
);
  logic [N-1:0] sync1_q;
  logic [N-1:0] sync2_q;
  logic [N-1:0] sync3_q;
  logic [N-1:0] level_q;
  logic [N-1:0] rise_q;
  logic [N-1:0] agree;

  // sampled on the fastest clock; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= src_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  assign agree = ~(sync2_q ^ sync3_q);

  // a change is accepted only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_q <= '0;
      rise_q  <= '0;
    end else begin
      level_q <= (agree & sync2_q) | (~agree & level_q);
      rise_q  <= agree & sync2_q & ~level_q;
    end
  end

  assign out_if.level = level_q;
  assign out_if.rise  = rise_q;
endmodule
`default_nettype wire

// ==== dv/evh_properties.sv ====
// port checker for the event handler
`timescale 1ns/1ps
`default_nettype none
module evh_properties (
  input wire logic        CORE_CLK,
  input wire logic        NRST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        WB_ERR_O,
  input wire logic        CPU_EVENT_LINE_ZERO,
  input wire logic        CPU_EVENT_LINE_ONE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  // a request the slave has not yet answered
  sequence s_take;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  endsequence
  // the answer cycle of a read at one offset
  sequence s_rd(logic [7:0] a);
    WB_ACK_O && !WB_WE_I && WB_ADR_I == a;
  endsequence
  a_ack_answer: assert property (s_take ##0 WB_ADR_I inside {8'h00, 8'h04, 8'h08, 8'h0C} |=> WB_ACK_O)
    else $error("mapped request not acked");
  a_err_answer: assert property (s_take ##0 !(WB_ADR_I inside {8'h00, 8'h04, 8'h08, 8'h0C}) |=> WB_ERR_O)
    else $error("unmapped request not refused");
  a_answer_pulse: assert property ((WB_ACK_O || WB_ERR_O) |=> !WB_ACK_O && !WB_ERR_O)
    else $error("answer longer than a cycle");
  a_line_clear: assert property (($fell(CPU_EVENT_LINE_ZERO) || $fell(CPU_EVENT_LINE_ONE)) |->
    $past(WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h00)) else $error("event line dropped without clear");
  a_reset_quiet: assert property (disable iff (1'b0) !NRST |=> !CPU_EVENT_LINE_ZERO && !CPU_EVENT_LINE_ONE)
    else $error("event line high after reset");
  a_code_none: assert property (s_rd(8'h08) ##0 $past(!CPU_EVENT_LINE_ZERO && !CPU_EVENT_LINE_ONE) |->
    WB_DAT_O == 32'h0000_00FF) else $error("code not FF with no event");
  a_code_high: assert property (s_rd(8'h08) ##0 $past(CPU_EVENT_LINE_ZERO) |->
    WB_DAT_O inside {[4:7]}) else $error("code not in high group");
  a_summary_match: assert property (s_rd(8'h0C) |->
    WB_DAT_O == {30'h0, $past(CPU_EVENT_LINE_ZERO), $past(CPU_EVENT_LINE_ONE)}) else $error("summary mismatch");
endmodule
bind evh_top evh_properties i_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
  .CPU_EVENT_LINE_ZERO(CPU_EVENT_LINE_ZERO), .CPU_EVENT_LINE_ONE(CPU_EVENT_LINE_ONE));
`default_nettype wire

// ==== dv/evh_peer.sv ====
// event sources and cpu event inputs beside the event handler
`timescale 1ns/1ps
`default_nettype none
module evh_peer (
  input  wire logic       clk,
  input  wire logic [7:0] fire,
  input  wire logic       line_zero,
  input  wire logic       line_one,
  output var  logic [7:0] src,
  output var  logic       woke
);
  // sources change just after an edge, as a peripheral flop would
  always_ff @(posedge clk) begin
    src <= fire;
  end
  // a halted cpu wakes on either level, pc untouched
  assign woke = line_zero | line_one;
endmodule
`default_nettype wire

// ==== dv/evh_tb_top.sv ====
// self-checking bench for the event handler
`timescale 1ns/1ps
`default_nettype none
module evh_tb_top;
  logic        clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, lz, lo, ack, err, woke;
  logic [7:0]  adr = 0, fire = 0, src;
  logic [31:0] dat = 0, q;
  int          num_errors = 0, checks_done = 0;
  always #2.5 clk = ~clk;
  evh_top i_dut (.CORE_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(q), .WB_ACK_O(ack), .WB_ERR_O(err), .EVENT_SRC(src),
    .CPU_EVENT_LINE_ZERO(lz), .CPU_EVENT_LINE_ONE(lo));
  evh_peer i_peer (.clk(clk), .fire(fire), .line_zero(lz), .line_one(lo), .src(src), .woke(woke));
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one classic cycle; result is {err, data}, released for a cycle after
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [32:0] r);
    int n;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      give_verdict();
    end
    r = {err, q};
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [32:0] r;
    bus(1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    logic [32:0] r;
    bus(0, a, 0, r);
    chk($sformatf("reg %h", a), r, x);
  endtask
  // fixed settle: filter plus flag plus line latency
  task automatic drive(input logic [7:0] v);
    fire <= v;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'hFF);
    rd(8'h0C, 8'h00);
    wr(8'h04, 8'hA5);
    rd(8'h04, 8'hA5);
    drive(8'h02);
    rd(8'h00, 8'h00);
    drive(8'h23);
    rd(8'h00, 8'h21);
    rd(8'h08, 8'h05);
    rd(8'h0C, 8'h03);
    chk("lines", {lz, lo, woke}, 3'b111);
    wr(8'h00, 8'h20);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h01);
    chk("lines", {lz, lo, woke}, 3'b011);
    wr(8'h00, 8'h01);
    wr(8'h08, 8'h00);
    rd(8'h08, 8'hFF);
    rd(8'h10, 33'h1_0000_0000);
    fire <= 8'h00;
    wr(8'h04, 8'hFF);
    drive(8'hFF);
    for (int i = 7; i >= 0; i--) begin
      rd(8'h08, i[7:0]);
      if (i == 3) rd(8'h0C, 8'h01);
      wr(8'h00, 8'h01 << i);
    end
    drive(8'h00);
    drive(8'h80);
    nrst <= 0;
    repeat (3) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'hFF);
    rd(8'h0C, 8'h00);
    chk("lines", {lz, lo, woke}, 3'b000);
    give_verdict();
  end
endmodule
`default_nettype wire
